// *** adcts_regs.svh ***
`ifndef ADCTS_REGS_SVH
`define ADCTS_REGS_SVH

// Register indices on the serial configuration port
`define ADCTS_ADDR_W        8
`define ADCTS_OFS_FOUR      8'h15
`define ADCTS_OFS_SIX       8'h16
`define ADCTS_OFS_TEMP      8'h17

// Field layout of each result register
`define ADCTS_REG_W         16
`define ADCTS_STAMP_MSB     15
`define ADCTS_STAMP_LSB     10
`define ADCTS_STAMP_W       6
`define ADCTS_DATA_MSB      9
`define ADCTS_DATA_LSB      0
`define ADCTS_DATA_W        10

// Reset values
`define ADCTS_STAMP_RST     6'h00
`define ADCTS_DATA_RST      10'h000
`define ADCTS_RDATA_RST     16'h0000

// Counter wrap point and input synchroniser depth
`define ADCTS_STAMP_MAX     6'h3F
`define ADCTS_SYNC_STAGES   2

// Channel count held in this bank
`define ADCTS_NUM_CH        3

// Code scaling: analog step in nanovolts, temperature in milli-degrees
`define ADCTS_AIN_LSB_NV    3519000
`define ADCTS_TEMP_LSB_MDEG 701.5
`define ADCTS_TEMP_OFS_MDEG 198360

`endif

// *** adcts_pkg.sv ***
`include "adcts_regs.svh"

package adcts_pkg;

   // Conversion source inside the monitoring converter
   typedef enum logic [1:0] {
      ADCTS_CH_FOUR,
      ADCTS_CH_SIX,
      ADCTS_CH_TEMP,
      ADCTS_CH_OTHER
   } adcts_chan_e;

   // One finished conversion from the converter sequencer
   typedef struct packed {
      logic                       valid;
      adcts_chan_e                chan;
      logic [`ADCTS_DATA_W-1:0]   data;
   } adcts_conv_s;

   // Layout of one result register, stamp on top
   typedef struct packed {
      logic [`ADCTS_STAMP_W-1:0]  stamp;
      logic [`ADCTS_DATA_W-1:0]   sample;
   } adcts_result_s;

endpackage : adcts_pkg

// *** adcts_stamp_counter.sv ***
`timescale 1ns/100ps
`include "adcts_regs.svh"

module adcts_stamp_counter #(
   parameter int STAMP_W = `ADCTS_STAMP_W
) (
   input  wire logic               mclk,
   input  wire logic               arst_n,
   input  wire logic               noninvertingDriveInput,
   output logic [STAMP_W-1:0]      stampCount,
   output logic                    driveEdge
);

   // Field width is fixed by the register layout
   if (STAMP_W != `ADCTS_STAMP_W) begin : g_bad_width
      $error("stamp counter width must match the stamp field");
   end

   logic               syncA_r;     // First synchroniser stage
   logic               syncB_r;     // Second synchroniser stage
   logic               prevB_r;     // Delayed copy for edge detection
   logic [STAMP_W-1:0] count_r;     // Shared time stamp counter
   logic [STAMP_W-1:0] count_nxt;

   // Either transition of the synchronised pin
   assign driveEdge  = syncB_r ^ prevB_r;
   assign stampCount = count_r;

   // Next count: one step per edge, wraps past the top
   always_comb begin
      count_nxt = count_r;
      if (driveEdge) begin
         if (count_r == `ADCTS_STAMP_MAX) begin
            count_nxt = `ADCTS_STAMP_RST;
         end else begin
            count_nxt = count_r + STAMP_W'(1);
         end
      end
   end

   // Synchroniser, edge history and counter registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_r <= 1'b0;
         syncB_r <= 1'b0;
         prevB_r <= 1'b0;
         count_r <= `ADCTS_STAMP_RST;
      end else begin
         syncA_r <= noninvertingDriveInput;
         syncB_r <= syncA_r;
         prevB_r <= syncB_r;
         count_r <= count_nxt;
      end
   end

endmodule : adcts_stamp_counter

// *** adcts_result_regs.sv ***
`timescale 1ns/100ps
`include "adcts_regs.svh"

module adcts_result_regs #(
   parameter int NUM_CH = `ADCTS_NUM_CH
) (
   input  wire logic                      mclk,
   input  wire logic                      arst_n,
   input  wire logic                      noninvertingDriveInput,
   input  wire adcts_pkg::adcts_conv_s    conv,
   input  wire logic                      rdEn,
   input  wire logic [`ADCTS_ADDR_W-1:0]  rdAddr,
   output logic [`ADCTS_REG_W-1:0]        rdData,
   output logic                           rdValid,
   input  wire logic                      wrEn,
   input  wire logic [`ADCTS_ADDR_W-1:0]  wrAddr,
   output logic                           wrDropped
);

   // Bank is laid out for exactly three result registers
   if (NUM_CH != `ADCTS_NUM_CH) begin : g_bad_count
      $error("result bank holds exactly three channels");
   end

   logic [`ADCTS_STAMP_W-1:0]  stampCount;     // Shared counter value
   logic                       driveEdge;      // Pin edge seen
   logic [NUM_CH-1:0]          convHit;        // Conversion per entry
   adcts_pkg::adcts_result_s   result_r   [NUM_CH];
   adcts_pkg::adcts_result_s   result_nxt [NUM_CH];
   logic [`ADCTS_REG_W-1:0]    rdData_r;       // Read answer word
   logic [`ADCTS_REG_W-1:0]    rdData_nxt;
   logic                       rdValid_r;      // Read answer strobe
   logic                       rdValid_nxt;
   logic                       wrDropped_r;    // Write refused strobe
   logic                       wrDropped_nxt;

   // Edge counter shared by all entries
   adcts_stamp_counter #(
      .STAMP_W                (`ADCTS_STAMP_W)
   ) u_stamp (
      .mclk                   (mclk),
      .arst_n                 (arst_n),
      .noninvertingDriveInput (noninvertingDriveInput),
      .stampCount             (stampCount),
      .driveEdge              (driveEdge)
   );

   // Decode which entry the finished conversion belongs to
   always_comb begin
      convHit = '0;
      if (conv.valid) begin
         unique case (conv.chan)
            adcts_pkg::ADCTS_CH_FOUR:  convHit[0] = 1'b1;
            adcts_pkg::ADCTS_CH_SIX:   convHit[1] = 1'b1;
            adcts_pkg::ADCTS_CH_TEMP:  convHit[2] = 1'b1;
            adcts_pkg::ADCTS_CH_OTHER: convHit    = '0;
         endcase
      end
   end

   // One result register per entry
   for (genvar i = 0; i < NUM_CH; i++) begin : g_entry
      // Next value: code and stamp only on own conversion
      always_comb begin
         result_nxt[i] = result_r[i];
         if (convHit[i]) begin
            // Raw code kept, so software scaling stays exact
            result_nxt[i].sample = conv.data;
            result_nxt[i].stamp  = stampCount;
         end
      end

      // Entry register, cleared on reset, no write path
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            result_r[i].stamp  <= `ADCTS_STAMP_RST;
            result_r[i].sample <= `ADCTS_DATA_RST;
         end else begin
            result_r[i] <= result_nxt[i];
         end
      end
   end

   // Read select and write refusal
   always_comb begin
      rdData_nxt    = rdData_r;
      rdValid_nxt   = rdEn;
      wrDropped_nxt = 1'b0;
      if (rdEn) begin
         unique case (rdAddr)
            `ADCTS_OFS_FOUR: rdData_nxt = result_r[0];
            `ADCTS_OFS_SIX:  rdData_nxt = result_r[1];
            `ADCTS_OFS_TEMP: rdData_nxt = result_r[2];
            default:         rdData_nxt = `ADCTS_RDATA_RST;
         endcase
      end
      // Read-only bank: writes are reported and discarded
      if (wrEn) begin
         unique case (wrAddr)
            `ADCTS_OFS_FOUR,
            `ADCTS_OFS_SIX,
            `ADCTS_OFS_TEMP: wrDropped_nxt = 1'b1;
            default:         wrDropped_nxt = 1'b0;
         endcase
      end
   end

   // Read port and write drop strobe registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_r    <= `ADCTS_RDATA_RST;
         rdValid_r   <= 1'b0;
         wrDropped_r <= 1'b0;
      end else begin
         rdData_r    <= rdData_nxt;
         rdValid_r   <= rdValid_nxt;
         wrDropped_r <= wrDropped_nxt;
      end
   end

   assign rdData    = rdData_r;
   assign rdValid   = rdValid_r;
   assign wrDropped = wrDropped_r;

   // Checks on the bank's own behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // Counter steps by one on each edge
   a_count_step: assert property (
      driveEdge && stampCount != `ADCTS_STAMP_MAX
      |=> stampCount == $past(stampCount) + 6'h01)
      else $error("stamp counter did not step on edge");

   // Counter holds without an edge
   a_count_idle: assert property (
      !driveEdge |=> $stable(stampCount))
      else $error("stamp counter moved without edge");

   // Counter wraps at the top
   a_count_wrap: assert property (
      driveEdge && stampCount == `ADCTS_STAMP_MAX
      |=> stampCount == `ADCTS_STAMP_RST)
      else $error("stamp counter did not wrap to zero");

   // Stamp taken from counter at conversion
   a_stamp_capture: assert property (
      convHit[1] |=> result_r[1].stamp == $past(stampCount))
      else $error("stamp not captured on conversion");

   // Stamp holds between conversions
   a_stamp_hold: assert property (
      !convHit[0] ##1 !convHit[0] |=> $stable(result_r[0].stamp))
      else $error("stamp changed without conversion");

   // Stamp taken on channel four conversion
   a_stamp_four: assert property (
      convHit[0] |=> result_r[0].stamp == $past(stampCount))
      else $error("channel four stamp not captured");

   // Stamp taken on temperature conversion
   a_stamp_temp: assert property (
      convHit[2] |=> result_r[2].stamp == $past(stampCount))
      else $error("temperature stamp not captured");

   // Whole six entry holds without its conversion
   a_hold_six: assert property (
      !convHit[1] |=> $stable(result_r[1]))
      else $error("channel six entry changed without conversion");

   // Whole temperature entry holds without its conversion
   a_hold_temp: assert property (
      !convHit[2] |=> $stable(result_r[2]))
      else $error("temperature entry changed without conversion");

   // Channel four code lands in low field
   a_data_four: assert property (
      convHit[0] |=> result_r[0].sample == $past(conv.data))
      else $error("channel four code not stored");

   // Channel six code lands in low field
   a_data_six: assert property (
      convHit[1] |=> result_r[1].sample == $past(conv.data))
      else $error("channel six code not stored");

   // Temperature code lands in low field
   a_data_temp: assert property (
      convHit[2] |=> result_r[2].sample == $past(conv.data))
      else $error("temperature code not stored");

   // Raw analog code is returned unscaled on read
   a_code_read: assert property (
      rdEn && rdAddr == `ADCTS_OFS_SIX && !convHit[1]
      |=> rdValid && rdData == $past(result_r[1]))
      else $error("channel six read does not match register");

   // Temperature code is returned unscaled on read
   a_temp_read: assert property (
      rdEn && rdAddr == `ADCTS_OFS_TEMP
      |=> rdData[`ADCTS_DATA_MSB:`ADCTS_DATA_LSB]
          == $past(result_r[2].sample))
      else $error("temperature read does not match register");

   // A write to the channel four register leaves it untouched
   a_write_ignored: assert property (
      wrEn && wrAddr == `ADCTS_OFS_FOUR && !convHit[0]
      |=> wrDropped && $stable(result_r[0]))
      else $error("write altered a read-only result");

   // Writes outside the bank raise no drop strobe
   a_write_other: assert property (
      wrEn && wrAddr != `ADCTS_OFS_FOUR && wrAddr != `ADCTS_OFS_SIX
      && wrAddr != `ADCTS_OFS_TEMP |=> !wrDropped)
      else $error("drop strobe raised for unmapped write");

   // Main scenarios
   c_wrap_seen: cover property (
      driveEdge && stampCount == `ADCTS_STAMP_MAX);
   c_conv_on_edge: cover property (driveEdge && convHit[0]);
   c_temp_read: cover property (
      convHit[2] ##1 rdEn && rdAddr == `ADCTS_OFS_TEMP);
   c_write_drop: cover property (wrDropped);

endmodule : adcts_result_regs

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "adcts_regs.svh"

module tb_top;
   logic                     mclk;                   // Bench clock
   logic                     arst_n;                 // Reset, active low
   logic                     noninvertingDriveInput; // Drive pin
   adcts_pkg::adcts_conv_s   conv;                   // Conversion bundle
   logic                     rdEn;                   // Read request
   logic [`ADCTS_ADDR_W-1:0] rdAddr;                 // Read index
   logic [`ADCTS_REG_W-1:0]  rdData;                 // Read word
   logic                     rdValid;                // Read strobe
   logic                     wrEn;                   // Write attempt
   logic [`ADCTS_ADDR_W-1:0] wrAddr;                 // Write index
   logic                     wrDropped;              // Write drop strobe
   integer                   n_mismatch = 0;         // Failed compares
   integer                   checked = 0;            // All compares
   integer                   seed = 26;              // Fixed random seed
   integer                   cycles = 0;             // Timeout counter
   logic [5:0]               cntMdl;                 // Expected stamp count
   logic [15:0]              regMdl [3];             // Four, six, temp

   // Device under test
   adcts_result_regs #(.NUM_CH(3)) i_adcts_result_regs (
      .mclk(mclk), .arst_n(arst_n),
      .noninvertingDriveInput(noninvertingDriveInput), .conv(conv),
      .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrDropped(wrDropped));

   // Free running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Counts, verdict and end of run
   task automatic summarize;
      $display("Compares %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Shared compare with report
   task automatic check(input logic [15:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // Expected read word per index
   function automatic logic [15:0] exp_word(input logic [7:0] a);
      case (a)
         `ADCTS_OFS_FOUR: exp_word = regMdl[0];
         `ADCTS_OFS_SIX:  exp_word = regMdl[1];
         `ADCTS_OFS_TEMP: exp_word = regMdl[2];
         default:         exp_word = 16'h0000; // Unmapped reads zero
      endcase
   endfunction : exp_word

   // One read, answer one cycle after the request is driven
   task automatic rd_chk(input logic [7:0] a);
      @(posedge mclk);
      rdEn <= 1'b1;
      rdAddr <= a;
      @(posedge mclk);
      rdEn <= 1'b0;
      #1;
      check({15'h0000, rdValid}, 16'h0001, "read strobe");
      check(rdData, exp_word(a), "read word");
   endtask : rd_chk

   // All three result registers
   task automatic rd_all;
      rd_chk(`ADCTS_OFS_FOUR);
      rd_chk(`ADCTS_OFS_SIX);
      rd_chk(`ADCTS_OFS_TEMP);
   endtask : rd_all

   // One write attempt and its drop strobe
   task automatic wr_chk(input logic [7:0] a, input logic exp);
      @(posedge mclk);
      wrEn <= 1'b1;
      wrAddr <= a;
      @(posedge mclk);
      wrEn <= 1'b0;
      #1;
      check(16'(wrDropped), 16'(exp), "write drop");
   endtask : wr_chk

   // Start a conversion cycle; model takes current count
   task automatic conv_put(input logic [1:0] ch, input logic [9:0] d);
      @(posedge mclk);
      conv <= {1'b1, ch, d};
      if (ch != 2'h3) regMdl[ch] = {cntMdl, d}; // Other source ignored
   endtask : conv_put

   // Close a run of conversions
   task automatic conv_end;
      @(posedge mclk);
      conv.valid <= 1'b0;
   endtask : conv_end

   // One pin edge, then wait past synchroniser latency
   task automatic toggle;
      @(posedge mclk);
      noninvertingDriveInput <= ~noninvertingDriveInput;
      cntMdl = cntMdl + 6'h01;
      repeat (5) @(posedge mclk);
   endtask : toggle

   // Reset pulse; model cleared
   task automatic do_reset(input int n);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (n) @(posedge mclk);
      arst_n <= 1'b1;
      cntMdl = 6'h00;
      regMdl = '{default: 16'h0000};
   endtask : do_reset

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 10000) begin
         n_mismatch++;
         $display("MISMATCH %0t run too long", $time);
         summarize();
      end
   end

   // Main sequence
   initial begin
      logic [1:0] ch;
      logic [9:0] d;
      arst_n = 1'b0;
      noninvertingDriveInput = 1'b0;
      conv = '0;
      rdEn = 1'b0;
      rdAddr = 8'h00;
      wrEn = 1'b0;
      wrAddr = 8'h00;
      do_reset(6);
      // Reset values and unmapped indices
      rd_all();
      rd_chk(8'h00);
      rd_chk(8'hFF);
      // Code extremes, back to back conversions
      conv_put(2'h2, 10'h3FF);
      conv_put(2'h0, 10'h001);
      conv_put(2'h1, 10'h2AA);
      conv_put(2'h3, 10'h155);
      conv_end();
      rd_all();
      // Writes to every register are dropped
      wr_chk(`ADCTS_OFS_FOUR, 1'b1);
      wr_chk(`ADCTS_OFS_SIX, 1'b1);
      wr_chk(`ADCTS_OFS_TEMP, 1'b1);
      wr_chk(8'h20, 1'b0);
      rd_all();
      // Counter past 63 wraps to zero
      repeat (65) toggle();
      conv_put(2'h1, 10'h0F0);
      conv_end();
      rd_all();
      // Random edges and conversions
      repeat (60) begin
         repeat ($unsigned($random(seed)) % 4) toggle();
         ch = 2'($random(seed));
         d = 10'($random(seed));
         conv_put(ch, d);
         conv_end();
         rd_all();
      end
      // Conversion taken in the cycle its edge is counted
      @(posedge mclk);
      noninvertingDriveInput <= ~noninvertingDriveInput;
      @(posedge mclk);
      conv_put(2'h0, 10'h2C3);
      cntMdl = cntMdl + 6'h01; // Edge counted after the capture
      conv_end();
      rd_all();
      // Reset in mid run, pin left low
      if (noninvertingDriveInput) toggle();
      do_reset(2);
      rd_all();
      summarize();
   end
endmodule : tb_top
